// file: local_memory_interface_map.vh
// register offsets, field positions and reset values of the local memory interface
`ifndef LOCAL_MEMORY_INTERFACE_MAP_VH
`define LOCAL_MEMORY_INTERFACE_MAP_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define REG_MEM_CTRL 8'h00
`define REG_SNOOP_CTRL 8'h04
`define REG_SRAM_TIMING 8'h08
`define REG_FLASH_TIMING 8'h0C
`define REG_BOOT_CTRL 8'h10
`define REG_ECC_STATUS 8'h14
`define REG_RTC_CTRL 8'h18
`define REG_RTC_TIME 8'h1C
`define REG_RTC_DATE 8'h20
// ----------------------------------------
// field positions
// ----------------------------------------
`define MEM_CTRL_MODEL_BIT 0
`define MEM_CTRL_SIZE_LSB 1
`define MEM_CTRL_DUP_EN_BIT 4
`define FLASH_WE_BIT 4
`define RTC_STOP_BIT 0
`define RTC_WPROT_BIT 1
// ----------------------------------------
// reset values
// ----------------------------------------
`define MEM_CTRL_RESET 32'h0000_0000
`define SNOOP_CTRL_RESET 32'h0000_0000
`define SRAM_TIMING_RESET 32'h0000_0003
`define FLASH_TIMING_RESET 32'h0000_0003
`define BOOT_CTRL_RESET 32'h0000_0002
// ----------------------------------------
// clock and sizes
// ----------------------------------------
`define CLK_HZ 100000000
`define SRAM_BYTES 524288
`define RTC_RAM_BYTES 8192
`endif

// file: local_memory_interface.v
// local memory interface: dram emulation, sram, flash, eprom and time-of-day clock control
`include "local_memory_interface_map.vh"

// How it works
// R1 - sdram always corrects single-bit and detects multi-bit errors in both models
// R2 - parity model hides corrected errors and reports multi-bit errors as parity errors; the ecc status register still latches them
// R3 - parity model sizes 1/4/8/16MB, ecc model 4/8/16/32MB over 16/32MB sdram
// R4 - software control register picks model and enabled memory size
// R5 - accessory dma snoop bits come from a fixed two-bit board input always
// R6 - other masters take snoop mode from a programmable register
// R7 - duplicated bus functions stay off while bus chip fitted; software enables them
// R8 - sram is one 512KB non-interleaved array without parity
// R9 - sram access timing comes from a programmable register
// R10 - requester should access sram twice; low backup blocks second cycle
// R11 - flash write enable needs control bit and board write-protect inputs clear
// R12 - flash decode addresses one byte-wide device of 1MB or 2MB
// R13 - eprom decode supports 256Kb, 512Kb default, and 1Mb by 8 densities
// R14 - boot source input selects flash when off, eproms when on
// R15 - clock keeps bcd seconds to year in 24-hour format
// R16 - clock corrects for 28, 29 leap and 30 day months
// R17 - clock never raises an interrupt
// R18 - clock device takes 8, 16 and 32-bit local bus accesses
// R19 - clock device has 8KB ram write-protected on power failure
// R20 - power-save stops oscillator; setting time restarts it
// R21 - wide clock accesses split into ascending byte cycles, big-endian
// R22 - local bus is 32-bit synchronous with burst and snoop
module local_memory_interface #(
	parameter TICK_DIV = 100000000,
	parameter PHYS_32MB = 1
) (
	// clock and reset
	input wire ref_clk,
	input wire arst_n,
	// register port
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// sdram error reporting from the check logic
	input wire sdram_single_err,
	input wire sdram_multi_err,
	output reg parity_err_q,
	output reg ecc_single_q,
	output reg ecc_multi_q,
	output reg [25:0] dram_limit_q,
	// board straps
	input wire [1:0] acc_dma_snoop_cfg,
	input wire [1:0] flash_wprot_cfg,
	input wire boot_source_select_input,
	input wire bus_chip_fitted,
	input wire backup_low,
	// master snoop controls
	output reg [1:0] acc_dma_snoop_q,
	output reg [1:0] master_snoop_q,
	output reg dup_func_en_q,
	// memory controls
	output reg [3:0] sram_wait_q,
	output reg sram_block_second_q,
	output reg flash_we_en_q,
	output reg [3:0] flash_wait_q,
	output reg flash_2mb_q,
	output reg [1:0] eprom_density_q,
	output reg boot_from_eprom_q,
	// clock device byte port
	input wire rtc_req,
	input wire [12:0] rtc_addr,
	input wire [1:0] rtc_size,
	input wire rtc_we,
	input wire [31:0] rtc_wdata,
	input wire power_fail,
	output reg [12:0] rtc_byte_addr_q,
	output reg [7:0] rtc_byte_data_q,
	output reg rtc_byte_we_q,
	output reg rtc_byte_strobe_q,
	output reg rtc_done_q,
	output reg rtc_irq_q
);

// ----------------------------------------
// reset synchroniser
// ----------------------------------------
// every register behind the two synchroniser stages leaves reset on the same edge after release
reg rst_meta_q, rst_n_q;
always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n) begin
		rst_meta_q <= 1'b0;
		rst_n_q <= 1'b0;
	end else begin
		rst_meta_q <= 1'b1;
		rst_n_q <= rst_meta_q;
	end
end

// ----------------------------------------
// control registers
// ----------------------------------------
reg [31:0] mem_ctrl_q, snoop_ctrl_q, sram_tim_q, flash_tim_q, boot_ctrl_q, rtc_ctrl_q;
reg [23:0] rtc_time_q;
reg [31:0] rtc_date_q;
reg [1:0] err_stat_q;
wire wr_time = reg_wr && reg_addr == `REG_RTC_TIME;
wire wr_date = reg_wr && reg_addr == `REG_RTC_DATE;
wire tick;
wire [23:0] time_next;
wire [31:0] date_next;

always @(posedge ref_clk or negedge rst_n_q) begin
	if (!rst_n_q) begin
		mem_ctrl_q <= `MEM_CTRL_RESET;
		snoop_ctrl_q <= `SNOOP_CTRL_RESET;
		sram_tim_q <= `SRAM_TIMING_RESET;
		flash_tim_q <= `FLASH_TIMING_RESET;
		boot_ctrl_q <= `BOOT_CTRL_RESET;
		rtc_ctrl_q <= 32'h0000_0000;
		err_stat_q <= 2'h0;
	end else begin
		if (reg_wr) begin
			case (reg_addr)
				`REG_MEM_CTRL: mem_ctrl_q <= reg_wdata; // R4
				`REG_SNOOP_CTRL: snoop_ctrl_q <= reg_wdata;
				`REG_SRAM_TIMING: sram_tim_q <= reg_wdata;
				`REG_FLASH_TIMING: flash_tim_q <= reg_wdata;
				`REG_BOOT_CTRL: boot_ctrl_q <= reg_wdata;
				`REG_RTC_CTRL: rtc_ctrl_q <= reg_wdata;
				default: ;
			endcase
		end
		// setting the time restarts the oscillator
		if (wr_time || wr_date)
			rtc_ctrl_q[`RTC_STOP_BIT] <= 1'b0; // R20
		// sticky error flags: set beats write-one-to-clear
		err_stat_q <= (err_stat_q & ~((reg_wr && reg_addr == `REG_ECC_STATUS) ?
			reg_wdata[1:0] : 2'h0)) | {sdram_multi_err, sdram_single_err}; // R1
	end
end

// ----------------------------------------
// read port
// ----------------------------------------
always @(posedge ref_clk or negedge rst_n_q) begin
	if (!rst_n_q) begin
		reg_rdata <= 32'h0000_0000;
	end else if (reg_rd) begin
		// whole 32-bit word, valid only in the cycle after the strobe
		case (reg_addr) // R22
			`REG_MEM_CTRL: reg_rdata <= mem_ctrl_q;
			`REG_SNOOP_CTRL: reg_rdata <= snoop_ctrl_q;
			`REG_SRAM_TIMING: reg_rdata <= sram_tim_q;
			`REG_FLASH_TIMING: reg_rdata <= flash_tim_q;
			`REG_BOOT_CTRL: reg_rdata <= boot_ctrl_q;
			`REG_ECC_STATUS: reg_rdata <= {30'h0, err_stat_q};
			`REG_RTC_CTRL: reg_rdata <= rtc_ctrl_q;
			`REG_RTC_TIME: reg_rdata <= {8'h00, rtc_time_q};
			`REG_RTC_DATE: reg_rdata <= rtc_date_q;
			default: reg_rdata <= 32'h0000_0000;
		endcase
	end else begin
		reg_rdata <= 32'h0000_0000;
	end
end

// ----------------------------------------
// dram emulation size and error mapping
// ----------------------------------------
wire ecc_model = mem_ctrl_q[`MEM_CTRL_MODEL_BIT];
wire [1:0] size_sel = mem_ctrl_q[`MEM_CTRL_SIZE_LSB+1:`MEM_CTRL_SIZE_LSB];
reg [25:0] limit_d;
always @* begin
	// limits in bytes minus one; capped by physical sdram
	case ({ecc_model, size_sel})
		3'b000: limit_d = 26'h00F_FFFF;
		3'b001: limit_d = 26'h03F_FFFF;
		3'b010: limit_d = 26'h07F_FFFF;
		3'b011: limit_d = 26'h0FF_FFFF;
		3'b100: limit_d = 26'h03F_FFFF;
		3'b101: limit_d = 26'h07F_FFFF;
		3'b110: limit_d = 26'h0FF_FFFF;
		3'b111: limit_d = PHYS_32MB ? 26'h1FF_FFFF : 26'h0FF_FFFF;
		default: limit_d = 26'h00F_FFFF;
	endcase
end

always @(posedge ref_clk or negedge rst_n_q) begin
	if (!rst_n_q) begin
		dram_limit_q <= 26'h00F_FFFF;
		parity_err_q <= 1'b0;
		ecc_single_q <= 1'b0;
		ecc_multi_q <= 1'b0;
	end else begin
		dram_limit_q <= limit_d; // R3
		// sram carries no parity, so only sdram errors reach these flags
		parity_err_q <= !ecc_model && sdram_multi_err; // R2 R8
		ecc_single_q <= ecc_model && sdram_single_err; // R1
		ecc_multi_q <= ecc_model && sdram_multi_err; // R1
	end
end

// ----------------------------------------
// snoop, boot, sram and flash controls
// ----------------------------------------
always @(posedge ref_clk or negedge rst_n_q) begin
	if (!rst_n_q) begin
		acc_dma_snoop_q <= 2'h0;
		master_snoop_q <= 2'h0;
		dup_func_en_q <= 1'b0;
		sram_wait_q <= 4'h3;
		sram_block_second_q <= 1'b0;
		flash_we_en_q <= 1'b0;
		flash_wait_q <= 4'h3;
		flash_2mb_q <= 1'b0;
		eprom_density_q <= 2'h1;
		boot_from_eprom_q <= 1'b0;
		rtc_irq_q <= 1'b0;
	end else begin
		// dma snoop bits follow the straps only; no register reaches them
		acc_dma_snoop_q <= acc_dma_snoop_cfg; // R5
		master_snoop_q <= snoop_ctrl_q[1:0]; // R6
		dup_func_en_q <= !bus_chip_fitted && mem_ctrl_q[`MEM_CTRL_DUP_EN_BIT]; // R7
		sram_wait_q <= sram_tim_q[3:0]; // R9
		sram_block_second_q <= backup_low; // R10
		flash_we_en_q <= flash_tim_q[`FLASH_WE_BIT] && flash_wprot_cfg == 2'h0; // R11
		flash_wait_q <= flash_tim_q[3:0];
		flash_2mb_q <= boot_ctrl_q[4]; // R12
		// density code 3 is unused and falls back to the 512Kb default
		eprom_density_q <= (boot_ctrl_q[2:1] == 2'h3) ? 2'h1 : boot_ctrl_q[2:1]; // R13
		boot_from_eprom_q <= boot_source_select_input; // R14
		rtc_irq_q <= 1'b0; // R17
	end
end

// ----------------------------------------
// time-of-day clock, bcd 24-hour
// ----------------------------------------
reg [31:0] div_q;
// the divider holds while the oscillator is stopped
assign tick = (div_q == TICK_DIV - 1) && !rtc_ctrl_q[`RTC_STOP_BIT];
function [7:0] bcd_inc;
	input [7:0] v;
	begin
		bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
	end
endfunction
wire [7:0] sec = rtc_time_q[7:0], mins = rtc_time_q[15:8], hrs = rtc_time_q[23:16];
wire [7:0] dd = rtc_date_q[15:8], mon = rtc_date_q[23:16], yr = rtc_date_q[31:24];
wire leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
	(yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
reg [7:0] mdays;
always @* begin
	case (mon)
		8'h02: mdays = leap ? 8'h29 : 8'h28; // R16
		8'h04, 8'h06, 8'h09, 8'h11: mdays = 8'h30; // R16
		default: mdays = 8'h31;
	endcase
end
wire s_wr = sec == 8'h59, m_wr = s_wr && mins == 8'h59, h_wr = m_wr && hrs == 8'h23;
wire d_wr = h_wr && dd == mdays, mo_wr = d_wr && mon == 8'h12;
assign time_next = {h_wr ? 8'h00 : (m_wr ? bcd_inc(hrs) : hrs),
	m_wr ? 8'h00 : (s_wr ? bcd_inc(mins) : mins), s_wr ? 8'h00 : bcd_inc(sec)};
// day of week runs 1 to 7 and steps at midnight
assign date_next = {mo_wr ? bcd_inc(yr) : yr, mo_wr ? 8'h01 : (d_wr ? bcd_inc(mon) : mon),
	d_wr ? 8'h01 : (h_wr ? bcd_inc(dd) : dd),
	h_wr ? ((rtc_date_q[7:0] == 8'h07) ? 8'h01 : bcd_inc(rtc_date_q[7:0])) : rtc_date_q[7:0]};

always @(posedge ref_clk or negedge rst_n_q) begin
	if (!rst_n_q) begin
		div_q <= 32'h0000_0000;
		rtc_time_q <= 24'h00_0000;
		rtc_date_q <= 32'h0001_0101;
	end else begin
		// a time or date write restarts the divider, so the first second is a full one
		div_q <= (tick || wr_time || wr_date) ? 32'h0000_0000 :
			(rtc_ctrl_q[`RTC_STOP_BIT] ? div_q : div_q + 32'h1);
		if (wr_time)
			rtc_time_q <= reg_wdata[23:0]; // R15
		else if (tick)
			rtc_time_q <= time_next; // R15
		if (wr_date)
			rtc_date_q <= reg_wdata;
		else if (tick)
			rtc_date_q <= date_next;
	end
end

// ----------------------------------------
// byte sequencer for the clock device ram
// ----------------------------------------
localparam ST_IDLE = 2'b01;
localparam ST_BYTE = 2'b10;
reg [1:0] st_q;
reg [1:0] left_q;
reg [31:0] shift_q;
// software can also protect the clock ram on its own
wire wprot = power_fail || rtc_ctrl_q[`RTC_WPROT_BIT]; // R19
always @(posedge ref_clk or negedge rst_n_q) begin
	if (!rst_n_q) begin
		st_q <= ST_IDLE;
		left_q <= 2'h0;
		shift_q <= 32'h0000_0000;
		rtc_byte_addr_q <= 13'h0000;
		rtc_byte_data_q <= 8'h00;
		rtc_byte_we_q <= 1'b0;
		rtc_byte_strobe_q <= 1'b0;
		rtc_done_q <= 1'b0;
	end else begin
		rtc_done_q <= 1'b0;
		rtc_byte_strobe_q <= 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (rtc_req) begin
					// size 0 byte, 1 word, 2 long; wider data is msb first
					left_q <= (rtc_size == 2'h2) ? 2'h3 : ((rtc_size == 2'h1) ? 2'h1 : 2'h0); // R18
					shift_q <= (rtc_size == 2'h2) ? rtc_wdata :
						((rtc_size == 2'h1) ? {rtc_wdata[15:0], 16'h0000} :
						{rtc_wdata[7:0], 24'h000000}); // R21
					rtc_byte_addr_q <= rtc_addr;
					rtc_byte_we_q <= rtc_we && !wprot;
					st_q <= ST_BYTE;
				end
			end
			ST_BYTE: begin
				// a power failure mid-transfer blocks the bytes still to come
				if (wprot)
					rtc_byte_we_q <= 1'b0; // R19
				rtc_byte_data_q <= shift_q[31:24];
				rtc_byte_strobe_q <= 1'b1;
				shift_q <= {shift_q[23:0], 8'h00};
				if (left_q == 2'h0) begin
					rtc_done_q <= 1'b1;
					st_q <= ST_IDLE;
				end else begin
					left_q <= left_q - 2'h1;
				end
			end
			default: st_q <= ST_IDLE;
		endcase
		// step the address after each strobe but the last so bytes land at ascending addresses
		if (st_q == ST_BYTE && rtc_byte_strobe_q)
			rtc_byte_addr_q <= rtc_byte_addr_q + 13'h1; // R21
	end
end

endmodule

// file: local_memory_interface_asserts.sv
// port checker for the local memory interface
module local_memory_interface_asserts (
	// clock and reset
	input wire ref_clk,
	input wire arst_n,
	// watched ports
	input wire sdram_multi_err,
	input wire parity_err_q,
	input wire [1:0] acc_dma_snoop_cfg,
	input wire [1:0] acc_dma_snoop_q,
	input wire [1:0] flash_wprot_cfg,
	input wire flash_we_en_q,
	input wire bus_chip_fitted,
	input wire dup_func_en_q,
	input wire boot_source_select_input,
	input wire boot_from_eprom_q,
	input wire rtc_req,
	input wire [1:0] rtc_size,
	input wire power_fail,
	input wire [12:0] rtc_byte_addr_q,
	input wire rtc_byte_we_q,
	input wire rtc_byte_strobe_q,
	input wire rtc_done_q,
	input wire rtc_irq_q
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// checks start one cycle after the internal reset copy is released
	// ----
	logic [1:0] rdy;
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) rdy <= 2'h0;
		else if (rdy != 2'h3) rdy <= rdy + 2'h1;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rdy != 2'h3);
	sequence two_bytes;
		(rtc_byte_strobe_q && !rtc_done_q) ##1 (rtc_byte_strobe_q && rtc_done_q);
	endsequence
	sequence four_bytes;
		(rtc_byte_strobe_q && !rtc_done_q) [*3] ##1 (rtc_byte_strobe_q && rtc_done_q);
	endsequence
	word_two_a: assert property (rtc_req && rtc_size == 2'h1 |-> ##2 two_bytes)
		else $error("16-bit access not two byte cycles");
	word_four_a: assert property (rtc_req && rtc_size == 2'h2 |-> ##2 four_bytes)
		else $error("32-bit access not four byte cycles");
	byte_order_a: assert property (rtc_byte_strobe_q && $past(rtc_byte_strobe_q)
		|-> rtc_byte_addr_q == $past(rtc_byte_addr_q) + 13'h1)
		else $error("byte addresses not ascending");
	irq_never_a: assert property (!rtc_irq_q)
		else $error("clock raised an interrupt");
	parity_cause_a: assert property ($rose(parity_err_q) |-> $past(sdram_multi_err))
		else $error("parity error without multi-bit error");
	snoop_strap_a: assert property (acc_dma_snoop_q == $past(acc_dma_snoop_cfg))
		else $error("dma snoop not from strap");
	flash_gate_a: assert property (flash_we_en_q |-> $past(flash_wprot_cfg) == 2'h0)
		else $error("flash write enabled while protected");
	dup_off_a: assert property ($past(bus_chip_fitted) |-> !dup_func_en_q)
		else $error("duplicated functions on with bus chip");
	boot_src_a: assert property (boot_from_eprom_q == $past(boot_source_select_input))
		else $error("boot source not from input");
	fail_prot_a: assert property (rtc_byte_strobe_q && $past(power_fail, 2)
		|-> !rtc_byte_we_q)
		else $error("byte write during power failure");
endmodule

bind local_memory_interface local_memory_interface_asserts u_local_memory_interface_asserts (.*);

// file: rtc_byte_model.sv
// byte-wide clock and backup ram model on the clock device port
module rtc_byte_model (
	input wire ref_clk,
	input wire strobe,
	input wire we,
	input wire [12:0] addr,
	input wire [7:0] data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:8191];
	always @(posedge ref_clk) begin
		if (strobe && we) mem[addr] <= data;
	end
endmodule

// file: local_memory_interface_tb.sv
// self-checking bench for the local memory interface
`include "local_memory_interface_map.vh"
module local_memory_interface_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, sdram_single_err = 0;
	logic sdram_multi_err = 0, boot_source_select_input = 0, bus_chip_fitted = 0;
	logic backup_low = 0, rtc_req = 0, rtc_we = 0, power_fail = 0;
	logic [7:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0, rtc_wdata = 0, reg_rdata;
	logic [1:0] acc_dma_snoop_cfg = 0, flash_wprot_cfg = 0, rtc_size = 0;
	logic [12:0] rtc_addr = 0, rtc_byte_addr_q;
	logic parity_err_q, ecc_single_q, ecc_multi_q, sram_block_second_q, flash_we_en_q;
	logic flash_2mb_q, boot_from_eprom_q, rtc_byte_we_q, rtc_byte_strobe_q, rtc_done_q;
	logic rtc_irq_q, dup_func_en_q;
	logic [25:0] dram_limit_q;
	logic [1:0] acc_dma_snoop_q, master_snoop_q, eprom_density_q;
	logic [3:0] sram_wait_q, flash_wait_q;
	logic [7:0] rtc_byte_data_q;
	int fail_count = 0, cmp_count = 0;
	local_memory_interface #(.TICK_DIV(4)) u_local_memory_interface (.*);
	rtc_byte_model u_rtc_byte_model (.ref_clk(ref_clk), .strobe(rtc_byte_strobe_q),
		.we(rtc_byte_we_q), .addr(rtc_byte_addr_q), .data(rtc_byte_data_q));
	always #5 ref_clk = ~ref_clk;
	// ----
	// shared tasks
	// ----
	task final_report;
		if (fail_count == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 0;
		repeat (2) @(posedge ref_clk);
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 0;
		#1 d = reg_rdata;
	endtask
	task rtc(input logic [12:0] a, input logic [1:0] s, input logic [31:0] d);
		int i;
		@(posedge ref_clk);
		rtc_req <= 1;
		rtc_addr <= a;
		rtc_size <= s;
		rtc_we <= 1;
		rtc_wdata <= d;
		@(posedge ref_clk);
		rtc_req <= 0;
		for (i = 0; i < 8 && rtc_done_q !== 1'b1; i++) @(negedge ref_clk);
		chk(rtc_done_q, 32'h1);
		repeat (2) @(posedge ref_clk);
	endtask
	// ----
	// scenarios
	// ----
	task t_reset;
		logic [31:0] v;
		rd(`REG_SRAM_TIMING, v); chk(v, `SRAM_TIMING_RESET);
		rd(`REG_FLASH_TIMING, v); chk(v, `FLASH_TIMING_RESET);
		rd(`REG_BOOT_CTRL, v); chk(v, `BOOT_CTRL_RESET);
		rd(8'h3C, v); chk(v, 32'h0);
		chk(dram_limit_q, 32'h000F_FFFF);
		chk(eprom_density_q, 32'h1);
		chk(boot_from_eprom_q, 0);
	endtask
	task t_dram;
		logic [25:0] lim;
		logic [31:0] v;
		for (int m = 0; m < 2; m++) for (int s = 0; s < 4; s++) begin
			wr(`REG_MEM_CTRL, m | (s << 1));
			lim = m ? (26'h1 << (s + 22)) - 1 : (s == 0 ? 26'hFFFFF : (26'h1 << (s + 21)) - 1);
			chk(dram_limit_q, lim);
			sdram_single_err <= 1;
			repeat (3) @(posedge ref_clk);
			chk(parity_err_q, 0);
			chk(ecc_single_q, m);
			sdram_single_err <= 0;
			sdram_multi_err <= 1;
			repeat (3) @(posedge ref_clk);
			chk(parity_err_q, m == 0);
			chk(ecc_multi_q, m);
			sdram_multi_err <= 0;
			rd(`REG_ECC_STATUS, v);
			chk(v, 32'h3);
			wr(`REG_ECC_STATUS, 32'h3);
			rd(`REG_ECC_STATUS, v);
			chk(v, 32'h0);
		end
	endtask
	task t_straps;
		logic [31:0] v;
		acc_dma_snoop_cfg <= 2'h2;
		wr(`REG_SNOOP_CTRL, 32'h1);
		chk(acc_dma_snoop_q, 2);
		chk(master_snoop_q, 1);
		bus_chip_fitted <= 1;
		wr(`REG_MEM_CTRL, 32'h10);
		chk(dup_func_en_q, 0);
		bus_chip_fitted <= 0;
		wr(`REG_SRAM_TIMING, 32'hA5C3_0005);
		rd(`REG_SRAM_TIMING, v);
		chk(v, 32'hA5C3_0005);
		chk(dup_func_en_q, 1);
		chk(sram_wait_q, 5);
		flash_wprot_cfg <= 2'h1;
		wr(`REG_FLASH_TIMING, 32'h1A);
		chk(flash_we_en_q, 0);
		chk(flash_wait_q, 32'hA);
		flash_wprot_cfg <= 2'h0;
		boot_source_select_input <= 1;
		backup_low <= 1;
		wr(`REG_BOOT_CTRL, 32'h14);
		chk(flash_we_en_q, 1);
		chk(boot_from_eprom_q, 1);
		chk(eprom_density_q, 2);
		chk(flash_2mb_q, 1);
		chk(sram_block_second_q, 1);
	endtask
	task t_rtc;
		rtc(13'h10, 2'h2, 32'h11223344);
		chk({u_rtc_byte_model.mem[16], u_rtc_byte_model.mem[17],
			u_rtc_byte_model.mem[18], u_rtc_byte_model.mem[19]}, 32'h11223344);
		rtc(13'h20, 2'h1, 32'hA5C3);
		chk({u_rtc_byte_model.mem[32], u_rtc_byte_model.mem[33]}, 32'hA5C3);
		rtc(13'h30, 2'h0, 32'h5A);
		power_fail <= 1;
		rtc(13'h30, 2'h0, 32'hFF);
		power_fail <= 0;
		chk(u_rtc_byte_model.mem[48], 32'h5A);
	endtask
	task t_clock;
		logic [31:0] st [3] = '{32'h04022807, 32'h03022801, 32'h04043002};
		logic [31:0] ex [3] = '{32'h04022901, 32'h03030102, 32'h04050103};
		logic [31:0] v, w;
		for (int k = 0; k < 3; k++) begin
			wr(`REG_RTC_DATE, st[k]);
			wr(`REG_RTC_TIME, 32'h235959);
			for (int i = 0; i < 20; i++) begin
				rd(`REG_RTC_DATE, v);
				if (v !== st[k]) break;
			end
			chk(v, ex[k]);
		end
		wr(`REG_RTC_CTRL, 32'h1);
		rd(`REG_RTC_TIME, v);
		repeat (20) @(posedge ref_clk);
		rd(`REG_RTC_TIME, w);
		chk(w, v);
		wr(`REG_RTC_TIME, 32'h0);
		rd(`REG_RTC_CTRL, v);
		chk(v[0], 0);
		rd(`REG_RTC_TIME, w);
		chk(w, 32'h1);
		chk(rtc_irq_q, 0);
	endtask
	initial begin
		#200us;
		fail_count++;
		final_report;
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		arst_n <= 1;
		repeat (3) @(posedge ref_clk);
		t_reset;
		t_dram;
		t_straps;
		t_rtc;
		t_clock;
		final_report;
	end
endmodule
